// ===== motion_status_config_regs.v
// How it works
// R1 - quiet event needs the upper-nibble count of consecutive samples under the lower limit.
// R2 - busy event needs the lower-nibble count of consecutive samples over the upper limit.
// R3 - tap axis field picks x with 00, y with 01 and z with 10.
// R4 - a set axis mask bit drops that axis from motion and stillness checking, clear by default.
// R5 - the upset flag is set by a register disturbance or while unconfigured.
// R6 - the upset flag is high at power-up and on every soft reset.
// R7 - the upset flag clears on any register write command.
// R8 - the awake bit is one while active, zero while inactive, reset one, mirror reset 0x40; here the mirror reads 0xC0 after reset, with upset set.
// R9 - the awake bit follows the detectors only in linked or loop chaining, else stays one.
// R10 - the stillness flag sets on an inactivity or free-fall detection.
// R11 - the motion flag sets on an over-threshold activity detection.
// R12 - aux samples compare by magnitude of the signed 14-bit value to 13-bit code limits.
// R13 - a failing sample restarts its consecutive-sample counter from zero.
// R14 - reserved bits read zero and writes to them do nothing.
`include "motion_status_config_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module motion_status_config_regs #(
  parameter SAMPLE_WIDTH = 14,
  parameter LIMIT_WIDTH = 13,
  parameter COUNT_WIDTH = 4
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address and data
  input wire [`ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [`ADDR_WIDTH-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // device events
  input wire soft_reset,
  input wire upset_event,
  input wire [2:0] axis_active,
  input wire [2:0] axis_inactive,
  input wire free_fall,
  // aux channel samples
  input wire aux_sample_valid,
  input wire [SAMPLE_WIDTH-1:0] aux_sample,
  // configuration and state out
  output reg [1:0] tap_axis_q,
  output reg [2:0] axis_check_en_q,
  output reg aux_busy_event_q,
  output reg aux_quiet_event_q,
  output reg awake_q
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // word address to register index, byte offset bits must be zero
  function [7:0] reg_index;
    input [`ADDR_WIDTH-1:0] addr;
    begin
      reg_index = addr[9:2];
    end
  endfunction

  // magnitude of a signed sample, same width read unsigned, so -8192 gives 8192
  function [SAMPLE_WIDTH-1:0] magnitude;
    input [SAMPLE_WIDTH-1:0] s;
    begin
      magnitude = s[SAMPLE_WIDTH-1] ? (~s + 1'b1) : s;
    end
  endfunction

  // a count of zero behaves as one sample
  function [COUNT_WIDTH-1:0] need;
    input [COUNT_WIDTH-1:0] n;
    begin
      need = (n == {COUNT_WIDTH{1'b0}}) ? {{(COUNT_WIDTH-1){1'b0}}, 1'b1} : n;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  reg [7:0] dwell_q;
  reg [7:0] axis_q;
  reg [7:0] ctrl_q;
  reg [LIMIT_WIDTH-1:0] upper_q;
  reg [LIMIT_WIDTH-1:0] lower_q;
  reg upset_q;
  reg still_q;
  reg motion_q;
  reg [`ADDR_WIDTH-1:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg aw_held_q;
  reg w_held_q;
  reg [COUNT_WIDTH-1:0] busy_cnt_q;
  reg [COUNT_WIDTH-1:0] quiet_cnt_q;

  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
  wire [7:0] wr_idx = reg_index(awaddr_q);
  wire wr_aligned = (awaddr_q[1:0] == 2'h0) &&
    (awaddr_q[`ADDR_WIDTH-1:10] == 2'h0);
  wire wr_lane0 = do_write & wr_aligned & wstrb_q[0];
  wire wr_lane1 = do_write & wr_aligned & wstrb_q[1];
  wire [7:0] status_word = {upset_q, awake_q, still_q, motion_q, 4'h0};

  ////////////////////////////////////////////////////////////////////////
  // aux channel comparison and detector combining

  wire [SAMPLE_WIDTH-1:0] aux_mag = magnitude(aux_sample);
  // R12 magnitude against limit codes
  wire aux_over = aux_mag > {{(SAMPLE_WIDTH-LIMIT_WIDTH){1'b0}}, upper_q};
  wire aux_under = aux_mag < {{(SAMPLE_WIDTH-LIMIT_WIDTH){1'b0}}, lower_q};
  wire [COUNT_WIDTH-1:0] busy_need = need(dwell_q[`DWELL_BUSY_HI:`DWELL_BUSY_LO]);
  wire [COUNT_WIDTH-1:0] quiet_need =
    need(dwell_q[`DWELL_QUIET_HI:`DWELL_QUIET_LO]);
  wire busy_run = aux_sample_valid & aux_over & ctrl_q[`CTRL_AUX_BUSY_EN];
  wire quiet_run = aux_sample_valid & aux_under & ctrl_q[`CTRL_AUX_QUIET_EN];
  // R2 busy event on reaching count
  wire busy_hit = busy_run && (busy_cnt_q + 1'b1 == busy_need);
  // R1 quiet event on reaching count
  wire quiet_hit = quiet_run && (quiet_cnt_q + 1'b1 == quiet_need);

  // R4 masked axes take no part; activity is any, stillness is all
  wire [2:0] axis_on = ~axis_q[2:0];
  wire axis_act = |(axis_active & axis_on);
  wire axis_still = (axis_on != 3'h0) && ((axis_inactive & axis_on) == axis_on);
  wire act_seen = axis_act | busy_hit;
  wire still_seen = axis_still | free_fall | quiet_hit;
  wire [1:0] chain = ctrl_q[`CTRL_CHAIN_HI:`CTRL_CHAIN_LO];
  wire chained = (chain == `CHAIN_LINKED) || (chain == `CHAIN_LOOP);
  wire status_read = ar_hs && (reg_index(s_axi_araddr) == `IDX_STATUS);
  wire sw_reset = ~aresetn | soft_reset;

  ////////////////////////////////////////////////////////////////////////
  // consecutive sample counters

  always @(posedge aclk)
  begin
    if (sw_reset || !aresetn)
    begin
      busy_cnt_q <= {COUNT_WIDTH{1'b0}};
      quiet_cnt_q <= {COUNT_WIDTH{1'b0}};
      aux_busy_event_q <= 1'b0;
      aux_quiet_event_q <= 1'b0;
    end
    else
    begin
      aux_busy_event_q <= busy_hit;
      aux_quiet_event_q <= quiet_hit;
      if (aux_sample_valid)
      begin
        // R13 broken run restarts count
        if (!busy_run)
          busy_cnt_q <= {COUNT_WIDTH{1'b0}};
        else if (busy_cnt_q != {COUNT_WIDTH{1'b1}})
          busy_cnt_q <= busy_cnt_q + 1'b1;
        // R13 broken run restarts count
        if (!quiet_run)
          quiet_cnt_q <= {COUNT_WIDTH{1'b0}};
        else if (quiet_cnt_q != {COUNT_WIDTH{1'b1}})
          quiet_cnt_q <= quiet_cnt_q + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers

  always @(posedge aclk)
  begin
    if (sw_reset)
    begin
      dwell_q <= `RST_DWELL;
      axis_q <= `RST_AXIS;
      ctrl_q <= `RST_CTRL;
      upper_q <= `RST_LIMIT;
      lower_q <= `RST_LIMIT;
    end
    else
    begin
      // R1 R2 both nibbles writable
      if (wr_lane0 && wr_idx == `IDX_DWELL)
        dwell_q <= wdata_q[7:0];
      if (wr_lane0 && wr_idx == `IDX_AXIS)
      begin
        // R14 reserved bits stay zero
        axis_q[2:0] <= wdata_q[2:0];
        // R3 reserved tap code ignored
        if (wdata_q[5:4] != `TAP_RESERVED)
          axis_q[5:4] <= wdata_q[5:4];
      end
      if (wr_lane0 && wr_idx == `IDX_CTRL)
        ctrl_q <= wdata_q[7:0] & `CTRL_RW_MASK;
      if (wr_lane0 && wr_idx == `IDX_UPPER)
        upper_q[7:0] <= wdata_q[7:0];
      if (wr_lane1 && wr_idx == `IDX_UPPER)
        upper_q[LIMIT_WIDTH-1:8] <= wdata_q[LIMIT_WIDTH-1:8];
      if (wr_lane0 && wr_idx == `IDX_LOWER)
        lower_q[7:0] <= wdata_q[7:0];
      if (wr_lane1 && wr_idx == `IDX_LOWER)
        lower_q[LIMIT_WIDTH-1:8] <= wdata_q[LIMIT_WIDTH-1:8];
    end
  end

  // registered copies of steering fields for the detectors
  always @(posedge aclk)
  begin
    if (sw_reset)
    begin
      tap_axis_q <= `TAP_X;
      axis_check_en_q <= 3'h7;
    end
    else
    begin
      // R3 tap axis out
      tap_axis_q <= axis_q[`AXIS_TAP_HI:`AXIS_TAP_LO];
      // R4 per-axis check enables
      axis_check_en_q <= axis_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status mirror; hardware set wins over any clear in the same cycle

  always @(posedge aclk)
  begin
    if (sw_reset)
    begin
      // R6 upset high after reset
      upset_q <= 1'b1;
      // R8 awake resets to one
      awake_q <= 1'b1;
      still_q <= 1'b0;
      motion_q <= 1'b0;
    end
    else
    begin
      // R5 disturbance sets upset
      if (upset_event)
        upset_q <= 1'b1;
      // R7 any write clears upset
      else if (do_write)
        upset_q <= 1'b0;
      // R10 stillness flag
      if (still_seen)
        still_q <= 1'b1;
      else if (status_read)
        still_q <= 1'b0;
      // R11 motion flag
      if (act_seen)
        motion_q <= 1'b1;
      else if (status_read)
        motion_q <= 1'b0;
      // R9 awake follows only when chained
      if (!chained)
        awake_q <= 1'b1;
      else if (act_seen)
        awake_q <= 1'b1;
      else if (still_seen)
        awake_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write side: address and data taken in either order

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= {`ADDR_WIDTH{1'b0}};
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end
    else
    begin
      if (aw_hs)
      begin
        awaddr_q <= s_axi_awaddr;
        aw_held_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (w_hs)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_held_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        case (wr_aligned ? wr_idx : 8'h00)
          `IDX_DWELL, `IDX_AXIS, `IDX_STATUS, `IDX_CTRL, `IDX_UPPER,
          `IDX_LOWER: s_axi_bresp <= `RESP_OKAY;
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end
      // one write at a time, reopen after the response is taken
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read side

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
      if (ar_hs)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        // R14 reserved and upper bits read zero
        case ((s_axi_araddr[1:0] == 2'h0 &&
               s_axi_araddr[`ADDR_WIDTH-1:10] == 2'h0) ?
              reg_index(s_axi_araddr) : 8'h00)
          `IDX_DWELL: s_axi_rdata <= {24'h000000, dwell_q};
          `IDX_AXIS: s_axi_rdata <= {24'h000000, axis_q & `AXIS_RW_MASK};
          `IDX_STATUS: s_axi_rdata <= {24'h000000, status_word};
          `IDX_CTRL: s_axi_rdata <= {24'h000000, ctrl_q};
          `IDX_UPPER: s_axi_rdata <= {19'h00000, upper_q};
          `IDX_LOWER: s_axi_rdata <= {19'h00000, lower_q};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // motion_status_config_regs

`default_nettype wire

// ===== motion_status_config_regs.vh
`ifndef MOTION_STATUS_CONFIG_REGS_VH
`define MOTION_STATUS_CONFIG_REGS_VH

// register indices as printed, byte address is four times the index
`define IDX_DWELL 8'h42
`define IDX_AXIS 8'h43
`define IDX_STATUS 8'h44
`define IDX_CTRL 8'h48
`define IDX_UPPER 8'h49
`define IDX_LOWER 8'h4A
`define ADDR_WIDTH 12

// reset values
`define RST_DWELL 8'h00
`define RST_AXIS 8'h00
`define RST_STATUS 8'h40
`define RST_CTRL 8'h00
`define RST_LIMIT 13'h0000

// dwell counts fields
`define DWELL_QUIET_HI 7
`define DWELL_QUIET_LO 4
`define DWELL_BUSY_HI 3
`define DWELL_BUSY_LO 0

// axis select fields
`define AXIS_TAP_HI 5
`define AXIS_TAP_LO 4
`define AXIS_Z_BLOCK 2
`define AXIS_Y_BLOCK 1
`define AXIS_X_BLOCK 0
`define AXIS_RW_MASK 8'h37
`define TAP_X 2'h0
`define TAP_Y 2'h1
`define TAP_Z 2'h2
`define TAP_RESERVED 2'h3

// status mirror fields
`define ST_UPSET 7
`define ST_AWAKE 6
`define ST_STILL 5
`define ST_MOTION 4

// control fields: chaining select, aux channel enables
`define CTRL_CHAIN_HI 1
`define CTRL_CHAIN_LO 0
`define CTRL_AUX_BUSY_EN 2
`define CTRL_AUX_QUIET_EN 3
`define CTRL_RW_MASK 8'h0F
`define CHAIN_DEFAULT 2'h0
`define CHAIN_LINKED 2'h1
`define CHAIN_LOOP 2'h3

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== motion_status_config_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module motion_status_config_regs_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // device side
  input wire logic soft_reset,
  input wire logic aux_sample_valid,
  input wire logic [1:0] tap_axis_q,
  input wire logic [2:0] axis_check_en_q,
  input wire logic aux_busy_event_q,
  input wire logic aux_quiet_event_q,
  input wire logic awake_q
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // both write halves, or a read, taken at one edge
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
  rd_zero_a: assert property (s_axi_rvalid |-> !(|s_axi_rdata[31:13]))
    else $error("read data high bits set");
  slverr_zero_a: assert property (
    s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("refused read not zero");
  reset_vals_a: assert property ($rose(aresetn) |-> awake_q
    && axis_check_en_q == 3'h7 && tap_axis_q == 2'h0)
    else $error("bad state after reset");
  soft_cfg_a: assert property (soft_reset |-> ##2
    axis_check_en_q == 3'h7 && tap_axis_q == 2'h0)
    else $error("bad state after soft reset");
  tap_legal_a: assert property (tap_axis_q != 2'h3)
    else $error("tap axis code three");
  // config moves only on write or soft reset
  cfg_cause_a: assert property (!$stable({tap_axis_q, axis_check_en_q})
    |-> $past(s_axi_bvalid) || $past(soft_reset) || $past(soft_reset, 2))
    else $error("config changed with no cause");
  busy_cause_a: assert property (aux_busy_event_q |->
    $past(aux_sample_valid) && !$past(aux_busy_event_q))
    else $error("busy pulse without sample");
  quiet_cause_a: assert property (aux_quiet_event_q |->
    $past(aux_sample_valid) && !$past(aux_quiet_event_q))
    else $error("quiet pulse without sample");
endmodule // motion_status_config_regs_props
bind motion_status_config_regs motion_status_config_regs_props props_inst (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .soft_reset,
  .aux_sample_valid, .tap_axis_q, .axis_check_en_q, .aux_busy_event_q,
  .aux_quiet_event_q, .awake_q
);
`default_nettype wire

// ===== axi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module axi_host_model (
  // clock
  input wire logic aclk,
  // write channels
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // read channels
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // idle bus from time zero
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hF;
  end
  ////////////////////////////////////////
  // each channel drops at its own ready; released lines show junk
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
    output logic [1:0] r);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      if (s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // read holds rready until the answer edge
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
    end while (s_axi_rvalid !== 1'b1);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
endmodule // axi_host_model
`default_nettype wire

// ===== test_motion_status_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "motion_status_config_regs.vh"
module test_motion_status_config_regs;
  logic aclk, aresetn, soft_reset, upset_event, free_fall, aux_sample_valid;
  logic [2:0] axis_active, axis_inactive;
  logic [13:0] aux_sample;
  wire [11:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp, tap_axis_q;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  wire s_axi_rvalid, s_axi_rready, aux_busy_event_q, aux_quiet_event_q;
  wire awake_q;
  wire [2:0] axis_check_en_q;
  int err_count, comparisons, cyc, busy_n, quiet_n;
  logic [31:0] rd_d;
  logic [1:0] resp;
  localparam logic [11:0] A_DW = {2'h0, `IDX_DWELL, 2'h0};
  localparam logic [11:0] A_AX = {2'h0, `IDX_AXIS, 2'h0};
  localparam logic [11:0] A_ST = {2'h0, `IDX_STATUS, 2'h0};
  localparam logic [11:0] A_CT = {2'h0, `IDX_CTRL, 2'h0};
  motion_status_config_regs motion_status_config_regs_inst (.*);
  axi_host_model axi_host_model_inst (.*);
  // 20 MHz clock
  initial aclk = 1'b0;
  always #25 aclk = ~aclk;
  ////////////////////////////////////////
  // hang guard and event pulse counters
  always @(posedge aclk)
  begin
    cyc++;
    busy_n += (aux_busy_event_q === 1'b1);
    quiet_n += (aux_quiet_event_q === 1'b1);
    if (cyc == 5000)
    begin
      err_count++;
      wrap_up;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e,
    input logic [1:0] er = `RESP_OKAY);
    axi_host_model_inst.rd(a, rd_d, resp);
    chk(rd_d, e);
    chk(resp, er);
  endtask
  task automatic wc(input logic [11:0] a, input logic [31:0] d,
    input logic [1:0] er = `RESP_OKAY);
    axi_host_model_inst.wr(a, d, resp);
    chk(resp, er);
  endtask
  // drive device inputs two cycles, then let flags settle
  task automatic pulse(input logic [2:0] busy_ax, still_ax, input logic ff);
    {axis_active, axis_inactive, free_fall} <= {busy_ax, still_ax, ff};
    repeat (2) @(posedge aclk);
    {axis_active, axis_inactive, free_fall} <= 7'h0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic smp(input logic [13:0] v);
    @(posedge aclk);
    {aux_sample_valid, aux_sample} <= {1'b1, v};
    @(posedge aclk);
    aux_sample_valid <= 1'b0;
  endtask
  task automatic t_axis;
    for (int i = 0; i < 3; i++)
    begin
      wc(A_AX, 32'hC8 | (i << 4) | (1 << i));
      rc(A_AX, (i << 4) | (1 << i));
      chk({tap_axis_q, axis_check_en_q}, {i[1:0], ~(3'h1 << i)});
    end
    wc(A_AX, 32'h30);
    rc(A_AX, 32'h20);
    wc(A_ST, 32'hFF);
    rc(A_ST, 32'h40);
    wc(12'h004, 32'h1, `RESP_SLVERR);
    rc(12'h004, 32'h0, `RESP_SLVERR);
    rc(A_DW | 12'h1, 32'h0, `RESP_SLVERR);
  endtask
  task automatic t_flags;
    upset_event <= 1'b1;
    @(posedge aclk);
    upset_event <= 1'b0;
    rc(A_ST, 32'hC0);
    wc(A_DW, 32'h0);
    rc(A_ST, 32'h40);
    pulse(3'h2, 3'h0, 1'b0);
    rc(A_ST, 32'h50);
    rc(A_ST, 32'h40);
    pulse(3'h0, 3'h7, 1'b0);
    rc(A_ST, 32'h60);
    pulse(3'h0, 3'h0, 1'b1);
    rc(A_ST, 32'h60);
    wc(A_AX, 32'h1);
    pulse(3'h1, 3'h6, 1'b0);
    rc(A_ST, 32'h60);
  endtask
  task automatic t_awake;
    for (int m = 1; m < 4; m += 2)
    begin
      wc(A_CT, m);
      pulse(3'h0, 3'h7, 1'b0);
      chk(awake_q, 1'b0);
      pulse(3'h2, 3'h0, 1'b0);
      chk(awake_q, 1'b1);
      rc(A_ST, 32'h70);
    end
    // code 2 is not a chaining mode, awake must hold at one
    wc(A_CT, 32'h2);
    pulse(3'h0, 3'h7, 1'b0);
    chk(awake_q, 1'b1);
  endtask
  task automatic t_aux;
    wc(A_CT + 12'h4, 32'd100);
    wc(A_CT + 12'h8, 32'd10);
    wc(A_DW, 32'h32);
    rc(A_DW, 32'h32);
    wc(A_CT, 32'h0C);
    smp(14'd200);
    smp(14'd100);
    smp(14'd200);
    repeat (3) @(posedge aclk);
    chk(busy_n, 0);
    smp(-14'sd300);
    repeat (3) @(posedge aclk);
    chk(busy_n, 1);
    smp(14'd5);
    smp(14'd10);
    smp(14'd5);
    smp(-14'sd5);
    repeat (3) @(posedge aclk);
    chk(quiet_n, 0);
    smp(14'd5);
    repeat (3) @(posedge aclk);
    chk({busy_n[15:0], quiet_n[15:0]}, 32'h10001);
  endtask
  task automatic wrap_up;
    if (err_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // reset, then each scenario in turn
  initial
  begin
    {aresetn, soft_reset, upset_event, free_fall, aux_sample_valid} = 5'h0;
    {axis_active, axis_inactive, aux_sample} = 20'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rc(A_ST, 32'hC0);
    rc(A_DW, 32'h0);
    chk({awake_q, axis_check_en_q, tap_axis_q}, 6'h3C);
    t_axis;
    t_flags;
    t_awake;
    t_aux;
    soft_reset <= 1'b1;
    @(posedge aclk);
    soft_reset <= 1'b0;
    rc(A_DW, 32'h0);
    chk(rd_d, 32'h0);
    axi_host_model_inst.rd(A_ST, rd_d, resp);
    chk(rd_d, 32'hC0);
    wrap_up;
  end
endmodule // test_motion_status_config_regs
`default_nettype wire
